// ---- dv/fpre_round_exc_checker.sv ----
`timescale 1ns/100ps
module fpre_round_exc_checker (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // operation
  input wire opValid,
  input wire opTrunc,
  input wire opCompare,
  input wire opNanResult,
  input wire [23:0] opMant,
  input wire opRound,
  input wire opSticky,
  input wire opExpOvf,
  input wire opInvalid,
  input wire opDenormal,
  input wire opDivZero,
  // response
  input wire resValid,
  input wire [23:0] resMant,
  input wire [5:0] resFlags,
  input wire trapReq
);
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire prePlain = !opInvalid && !opDenormal && !opDivZero;
  // only ops that really go through rounding
  wire plain = opValid && prePlain && !opExpOvf && !opCompare && !opNanResult;
  wire lost = opRound || opSticky;

  property p_res_pulse; opValid |=> resValid; endproperty
  property p_res_idle; !opValid |=> !resValid && !trapReq; endproperty
  property p_pre_flags;
    opValid |=> resFlags[2:0] ==
      {$past(opDivZero), $past(opDenormal), $past(opInvalid)};
  endproperty
  property p_inexact; plain && lost |=> resFlags[5]; endproperty
  property p_exact; plain && !lost |=> !resFlags[5]; endproperty
  property p_cmp_nan;
    opValid && (opCompare || opNanResult) |=> !resFlags[5] && !resFlags[3];
  endproperty
  property p_trunc;
    plain && opTrunc |=> trapReq || resMant == $past(opMant);
  endproperty
  property p_trap_valid; trapReq |-> resValid; endproperty

  a_res_pulse: assert property (p_res_pulse)
    else $error("no result after op");
  a_res_idle: assert property (p_res_idle)
    else $error("result or trap without op");
  a_pre_flags: assert property (p_pre_flags)
    else $error("pre-computation flags wrong");
  a_inexact: assert property (p_inexact)
    else $error("inexact result without precision flag");
  a_exact: assert property (p_exact)
    else $error("exact result with precision flag");
  a_cmp_nan: assert property (p_cmp_nan)
    else $error("compare or nan op rounded");
  a_trunc: assert property (p_trunc)
    else $error("truncating conversion rounded up");
  a_trap_valid: assert property (p_trap_valid)
    else $error("trap without result");

  c_trunc: cover property (opValid && opTrunc);
  c_trap: cover property (trapReq);
  c_multi: cover property (resValid && resFlags == 6'h32);
endmodule // fpre_round_exc_checker

bind fpre_round_exc fpre_round_exc_checker u_chk (.*);

// ---- dv/tb.sv ----
`timescale 1ns/100ps
`include "fpre_map.vh"
`define CHK(n, e, g) begin nTests++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
  logic clk_sys = 0, resetn = 0, regWrEn = 0, regRdEn = 0, opValid = 0;
  logic [3:0] regAddr = 0;
  logic [31:0] regWrData = 0, regRdData;
  logic opSimd = 0, opTrunc = 0, opCompare = 0, opNanResult = 0, opSignA = 0;
  logic opSignB = 0, opSign = 0, opRound = 0, opSticky = 0, opExpMax = 0;
  logic opExpOvf = 0, opTiny = 0, opInvalid = 0, opDenormal = 0, opDivZero = 0;
  logic [23:0] opMant = 0, resMant;
  logic resValid, resSign, trapReq;
  logic [1:0] resKind;
  logic [5:0] resFlags;
  int miscompares = 0, nTests = 0;
  localparam logic [14:0] kSimd = 15'h4000, kTrunc = 15'h2000;
  localparam logic [14:0] kCmp = 15'h1000, kNan = 15'h0800, kSgnA = 15'h0400;
  localparam logic [14:0] kSign = 15'h0100, kRnd = 15'h0080, kStk = 15'h0040;
  localparam logic [14:0] kOvf = 15'h0010, kTiny = 15'h0008, kInv = 15'h0004;
  localparam logic [14:0] kDen = 15'h0002, kDz = 15'h0001;
  localparam logic [14:0] kSgnB = 15'h0200, kExpMax = 15'h0020;

  fpre_round_exc u_dut (.*);

  // ************************************************************
  // bus and op drivers
  // ************************************************************
  initial forever #5 clk_sys = ~clk_sys;
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask
  task automatic rdChk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    #1 `CHK("regRdData", e, regRdData)
  endtask
  // results are sampled just after the edge that registers them
  task automatic op(input logic [14:0] c, input logic [23:0] m);
    @(posedge clk_sys);
    {opSimd, opTrunc, opCompare, opNanResult, opSignA, opSignB, opSign,
     opRound, opSticky, opExpMax, opExpOvf, opTiny, opInvalid, opDenormal,
     opDivZero} <= c;
    opMant <= m;
    opValid <= 1'b1;
    @(posedge clk_sys);
    opValid <= 1'b0;
    #1 `CHK("resValid", 1'b1, resValid)
  endtask
  task automatic opChk(input logic [14:0] c, input logic [5:0] f,
                       input logic t, input logic [1:0] k);
    op(c, 24'h00_0005);
    `CHK("resFlags", f, resFlags)
    `CHK("trapReq", t, trapReq)
    if (!t) `CHK("resKind", k, resKind)
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    rdChk(4'h0, 32'h0000_003f);
    rdChk(4'h4, 32'h0000_0000);
    rdChk(4'h8, 32'h0000_1f80);
    rdChk(4'hc, 32'h0000_0000);
  endtask
  // simd field always set to another mode than the scalar one
  task automatic t_round;
    logic [4:0] b;
    logic [23:0] m;
    logic i;
    int e;
    for (int md = 0; md < 4; md++) begin
      wr(4'h0, 32'h0000_003f | md << 10);
      wr(4'h8, 32'h0000_1f80 | (3 - md) << 13);
      for (int k = 0; k < 32; k++) begin
        b = k[4:0];
        e = b[4] ? 3 - md : md;
        case (e)
          0: i = b[1] & (b[0] | b[2]);
          1: i = b[3] & (b[1] | b[0]);
          2: i = !b[3] & (b[1] | b[0]);
          default: i = 1'b0;
        endcase
        m = 24'hc0_0010 | b[2];
        op({b[4], 5'h00, b[3], b[1], b[0], 6'h00}, m);
        `CHK("resMant", m + i, resMant)
        `CHK("precision", b[1] | b[0], resFlags[5])
      end
    end
  endtask
  task automatic t_special;
    wr(4'h0, 32'h0000_003f);
    wr(4'h8, 32'h0000_5f80);
    op(kTrunc | kRnd | kStk, 24'h00_0005);
    `CHK("resMant", 24'h00_0005, resMant)
    op(kSimd | kTrunc | kRnd, 24'h00_0005);
    `CHK("resMant", 24'h00_0005, resMant)
    opChk(kCmp | kRnd | kStk, 6'h00, 1'b0, `FPRE_KIND_FINITE);
    opChk(kNan | kRnd | kStk, 6'h00, 1'b0, `FPRE_KIND_QNAN);
  endtask
  task automatic t_sticky;
    wr(4'h4, 32'h0000_0000);
    wr(4'h8, 32'h0000_1f80);
    op(kRnd, 24'h00_0004);
    op(15'h0000, 24'h00_0004);
    rdChk(4'h4, 32'h0000_0020);
    rdChk(4'h8, 32'h0000_1f80);
    wr(4'h4, 32'h0000_0000);
    rdChk(4'h4, 32'h0000_0000);
  endtask
  task automatic t_masked;
    opChk(kInv, 6'h01, 1'b0, `FPRE_KIND_QNAN);
    opChk(kDz | kSgnA, 6'h04, 1'b0, `FPRE_KIND_INF);
    `CHK("resSign", 1'b1, resSign)
    opChk(kDz | kSgnA | kSgnB, 6'h04, 1'b0, `FPRE_KIND_INF);
    `CHK("resSign", 1'b0, resSign)
    opChk(kDen | kTiny | kRnd, 6'h32, 1'b0, `FPRE_KIND_FINITE);
    opChk(kOvf, 6'h28, 1'b0, `FPRE_KIND_INF);
    // rounding carry out of the top exponent overflows
    op(kExpMax | kRnd | kStk, 24'hff_ffff);
    `CHK("resFlags", 6'h28, resFlags)
    `CHK("resKind", `FPRE_KIND_INF, resKind)
    wr(4'h0, 32'h0000_0c3f);
    opChk(kOvf | kSign, 6'h28, 1'b0, `FPRE_KIND_MAXFIN);
    `CHK("resMant", 24'hff_ffff, resMant)
  endtask
  task automatic t_trap;
    wr(4'h0, 32'h0000_003e);
    wr(4'h8, 32'h0000_1d80);
    opChk(kInv, 6'h01, 1'b1, 2'h0);
    // a trapped op leaves the previous result in place
    `CHK("resKind", `FPRE_KIND_MAXFIN, resKind)
    opChk(kSimd | kDz, 6'h04, 1'b1, 2'h0);
    opChk(kDz, 6'h04, 1'b0, `FPRE_KIND_INF);
    wr(4'h0, 32'h0000_002e);
    opChk(kTiny, 6'h10, 1'b1, 2'h0);
  endtask
  task automatic t_rerun;
    wr(4'h8, 32'h0000_6000);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    rdChk(4'h8, 32'h0000_1f80);
    rdChk(4'h0, 32'h0000_003f);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // the run needs about 360 cycles; the ceiling leaves wide margin
  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset;
    t_round;
    t_special;
    t_sticky;
    t_masked;
    t_trap;
    t_rerun;
    end_sim;
  end
endmodule // tb

// ---- hw/fpre_map.vh ----
`ifndef FPRE_MAP_VH
`define FPRE_MAP_VH

// ************************************************************
// register offsets (byte addresses on the plain port)
// ************************************************************
`define FPRE_ADDR_W 4
`define FPRE_OFS_SCALAR_CTRL 4'h0
`define FPRE_OFS_SCALAR_STAT 4'h4
`define FPRE_OFS_SIMD_CSR 4'h8

// ************************************************************
// exception bit positions, shared by every flag and mask group
// ************************************************************
`define FPRE_EXC_INV 0
`define FPRE_EXC_DEN 1
`define FPRE_EXC_DZ 2
`define FPRE_EXC_OVF 3
`define FPRE_EXC_UNF 4
`define FPRE_EXC_PREC 5
`define FPRE_EXC_N 6

// ************************************************************
// field positions
// ************************************************************
`define FPRE_SC_MASK_LO 0
`define FPRE_SC_RC_LO 10
`define FPRE_SD_FLAG_LO 0
`define FPRE_SD_MASK_LO 7
`define FPRE_SD_RC_LO 13

// ************************************************************
// rounding modes
// ************************************************************
`define FPRE_RC_NEAREST 2'h0
`define FPRE_RC_DOWN 2'h1
`define FPRE_RC_UP 2'h2
`define FPRE_RC_ZERO 2'h3

// ************************************************************
// result kinds and reset values
// ************************************************************
`define FPRE_KIND_FINITE 2'h0
`define FPRE_KIND_INF 2'h1
`define FPRE_KIND_MAXFIN 2'h2
`define FPRE_KIND_QNAN 2'h3
`define FPRE_MASK_RST 6'h3f
`define FPRE_FLAG_RST 6'h00
`define FPRE_MANT_W 24

`endif

// ---- hw/fpre_round_exc.v ----
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "fpre_map.vh"

// How it works
// (RQ1) mode 00: round to nearest, ties go to the even value
// (RQ2) mode 01: round toward minus infinity
// (RQ3) mode 10: round toward plus infinity
// (RQ4) mode 11: truncate toward zero
// (RQ5) rounding fields reset to round-to-nearest-even
// (RQ6) pick between two bracketing neighbours, error under one ulp
// (RQ7) any result differing from the exact value sets the precision flag
// (RQ8) compares, exact results and NaN results ignore the rounding mode
// (RQ9) two-bit field: scalar control bits 11:10, SIMD csr bits 14:13
// (RQ10) scalar field rounds scalar ops only, SIMD field SIMD ops only
// (RQ11) truncating float-to-integer conversions always round toward zero
// (RQ12) detect invalid, divide-by-zero, denormal, overflow, underflow, inexact
// (RQ13) invalid, divide, denormal checked before; the rest after computing
// (RQ14) each class has flag and mask; flags set before the response
// (RQ15) masked exception gives a default result, execution continues
// (RQ16) unmasked exception raises a software handler request
// (RQ17) flags are sticky until software clears them
// (RQ18) scalar flags status bits 5:0, masks control bits 5:0
// (RQ19) SIMD csr flags bits 5:0, masks bits 12:7
// (RQ20) scalar flags and masks serve scalar ops, SIMD ones SIMD ops
// (RQ21) after a masked response the op continues, setting more flags
// (RQ22) masked invalid sets its flag and returns the quiet NaN indefinite
// (RQ23) masked divide-by-zero returns infinity, sign = xor of operand signs
// (RQ24) masked overflow returns infinity or largest finite by rounding mode
// (RQ25) bit order: invalid 0, denormal 1, divide 2, overflow 3, under 4, prec 5

module fpre_round_exc (
  // clock and reset
  input wire clk_sys,
  input wire resetn,
  // register port
  input wire [`FPRE_ADDR_W-1:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrEn,
  input wire regRdEn,
  output reg [31:0] regRdData,
  // operation from the arithmetic core
  input wire opValid,
  input wire opSimd,
  input wire opTrunc,
  input wire opCompare,
  input wire opNanResult,
  input wire opSignA,
  input wire opSignB,
  input wire opSign,
  input wire [`FPRE_MANT_W-1:0] opMant,
  input wire opRound,
  input wire opSticky,
  input wire opExpMax,
  input wire opExpOvf,
  input wire opTiny,
  input wire opInvalid,
  input wire opDenormal,
  input wire opDivZero,
  // rounded result and response
  output reg resValid,
  output reg resSign,
  output reg [`FPRE_MANT_W-1:0] resMant,
  output reg [1:0] resKind,
  output reg [`FPRE_EXC_N-1:0] resFlags,
  output reg trapReq
);

  // ************************************************************
  // functions
  // ************************************************************
  // increment decision on the truncated significand
  function roundUp;
    input [1:0] mode;
    input sign;
    input lsb;
    input rnd;
    input stk;
    begin
      case (mode)
        `FPRE_RC_NEAREST: roundUp = rnd & (stk | lsb); // RQ1
        `FPRE_RC_DOWN: roundUp = sign & (rnd | stk); // RQ2
        `FPRE_RC_UP: roundUp = ~sign & (rnd | stk); // RQ3
        `FPRE_RC_ZERO: roundUp = 1'b0; // RQ4
        default: roundUp = 1'b0;
      endcase
    end
  endfunction

  // modes and signs where a masked overflow answers largest finite instead of infinity
  function ovfToMax;
    input [1:0] mode;
    input sign;
    begin
      case (mode)
        `FPRE_RC_NEAREST: ovfToMax = 1'b0;
        `FPRE_RC_DOWN: ovfToMax = ~sign;
        `FPRE_RC_UP: ovfToMax = sign;
        `FPRE_RC_ZERO: ovfToMax = 1'b1;
        default: ovfToMax = 1'b0;
      endcase
    end
  endfunction

  // sticky flag update; set beats a clearing write
  function [`FPRE_EXC_N-1:0] flagNext;
    input [`FPRE_EXC_N-1:0] cur;
    input wr;
    input [`FPRE_EXC_N-1:0] wrVal;
    input [`FPRE_EXC_N-1:0] set;
    begin
      flagNext = (wr ? wrVal : cur) | set;
    end
  endfunction

  // exact offset match; unmapped offsets hit nothing
  function hitReg;
    input [`FPRE_ADDR_W-1:0] addr;
    input [`FPRE_ADDR_W-1:0] ofs;
    begin
      hitReg = (addr == ofs);
    end
  endfunction

  // ************************************************************
  // control and status registers
  // ************************************************************
  reg [`FPRE_EXC_N-1:0] scMask;
  reg [1:0] scRc;
  reg [`FPRE_EXC_N-1:0] scFlag;
  reg [`FPRE_EXC_N-1:0] sdMask;
  reg [1:0] sdRc;
  reg [`FPRE_EXC_N-1:0] sdFlag;

  wire wrScCtrl;
  wire wrScStat;
  wire wrSdCsr;
  assign wrScCtrl = regWrEn & hitReg(regAddr, `FPRE_OFS_SCALAR_CTRL);
  assign wrScStat = regWrEn & hitReg(regAddr, `FPRE_OFS_SCALAR_STAT);
  assign wrSdCsr = regWrEn & hitReg(regAddr, `FPRE_OFS_SIMD_CSR);

  // ************************************************************
  // write word fields
  // ************************************************************
  wire [`FPRE_EXC_N-1:0] wrScMask;
  wire [1:0] wrScRc;
  wire [`FPRE_EXC_N-1:0] wrScFlag;
  wire [`FPRE_EXC_N-1:0] wrSdFlag;
  wire [`FPRE_EXC_N-1:0] wrSdMask;
  wire [1:0] wrSdRc;

  assign wrScMask = regWrData[`FPRE_SC_MASK_LO+`FPRE_EXC_N-1:
    `FPRE_SC_MASK_LO];
  assign wrScRc = regWrData[`FPRE_SC_RC_LO+1:`FPRE_SC_RC_LO];
  assign wrScFlag = regWrData[`FPRE_EXC_N-1:0];
  // one word carries flags, masks and mode of the SIMD unit
  assign wrSdFlag = regWrData[`FPRE_SD_FLAG_LO+`FPRE_EXC_N-1:
    `FPRE_SD_FLAG_LO];
  assign wrSdMask = regWrData[`FPRE_SD_MASK_LO+`FPRE_EXC_N-1:
    `FPRE_SD_MASK_LO];
  assign wrSdRc = regWrData[`FPRE_SD_RC_LO+1:`FPRE_SD_RC_LO];

  // ************************************************************
  // operand-side selection
  // ************************************************************
  wire [1:0] selRc;
  wire [1:0] mode;
  wire [`FPRE_EXC_N-1:0] selMask;

  assign selRc = opSimd ? sdRc : scRc; // RQ10
  assign mode = opTrunc ? `FPRE_RC_ZERO : selRc; // RQ11
  assign selMask = opSimd ? sdMask : scMask; // RQ20

  // ************************************************************
  // pre-computation checks
  // ************************************************************
  reg [`FPRE_EXC_N-1:0] preDet;
  wire preTrap;

  always @* begin
    preDet = {`FPRE_EXC_N{1'b0}};
    preDet[`FPRE_EXC_INV] = opInvalid; // RQ12
    preDet[`FPRE_EXC_DEN] = opDenormal; // RQ25
    preDet[`FPRE_EXC_DZ] = opDivZero; // RQ25
  end

  // an unmasked early fault stops before any arithmetic
  assign preTrap = |(preDet & ~selMask); // RQ13

  // ************************************************************
  // rounding
  // ************************************************************
  wire noRound;
  wire inexact;
  wire incr;
  wire [`FPRE_MANT_W:0] mantSum;
  wire carry;
  wire [`FPRE_MANT_W-1:0] mantRnd;

  // invalid and divide answers are special values, never rounded
  assign noRound = opCompare | opNanResult | opInvalid | opDivZero; // RQ8
  assign inexact = ~noRound & (opRound | opSticky); // RQ7
  assign incr = ~noRound &
    roundUp(mode, opSign, opMant[0], opRound, opSticky); // RQ6
  assign mantSum = {1'b0, opMant} + {{`FPRE_MANT_W{1'b0}}, incr};
  assign carry = mantSum[`FPRE_MANT_W];
  // a carry out leaves 1.000..: renormalise by one place
  assign mantRnd = carry ? mantSum[`FPRE_MANT_W:1] :
    mantSum[`FPRE_MANT_W-1:0];

  // ************************************************************
  // post-computation checks
  // ************************************************************
  wire ovf;
  wire unf;
  reg [`FPRE_EXC_N-1:0] postDet;
  wire [`FPRE_EXC_N-1:0] det;
  wire trap;

  assign ovf = ~noRound & (opExpOvf | (carry & opExpMax));
  // unmasked underflow reports on tiny alone, masked needs inexact too
  assign unf = ~noRound & opTiny &
    (inexact | ~selMask[`FPRE_EXC_UNF]);

  always @* begin
    postDet = {`FPRE_EXC_N{1'b0}};
    postDet[`FPRE_EXC_OVF] = ovf; // RQ12
    postDet[`FPRE_EXC_UNF] = unf;
    // a masked overflow answer is itself inexact
    postDet[`FPRE_EXC_PREC] = inexact |
      (ovf & selMask[`FPRE_EXC_OVF]); // RQ7
  end

  // masked early faults fall through to the later checks
  assign det = preDet | (preTrap ? {`FPRE_EXC_N{1'b0}} : postDet); // RQ21
  assign trap = |(det & ~selMask); // RQ16

  // ************************************************************
  // result selection
  // ************************************************************
  reg [1:0] next_kind;
  reg next_sign;
  reg [`FPRE_MANT_W-1:0] next_mant;

  always @* begin
    next_kind = `FPRE_KIND_FINITE;
    next_sign = opSign;
    next_mant = mantRnd;
    if (opNanResult || det[`FPRE_EXC_INV]) begin
      next_kind = `FPRE_KIND_QNAN; // RQ22
      next_mant = opMant;
    end else if (det[`FPRE_EXC_DZ]) begin
      next_kind = `FPRE_KIND_INF; // RQ23
      next_sign = opSignA ^ opSignB;
      next_mant = {`FPRE_MANT_W{1'b0}};
    end else if (ovf) begin
      if (ovfToMax(mode, opSign)) begin
        next_kind = `FPRE_KIND_MAXFIN; // RQ24
        next_mant = {`FPRE_MANT_W{1'b1}};
      end else begin
        next_kind = `FPRE_KIND_INF; // RQ24
        next_mant = {`FPRE_MANT_W{1'b0}};
      end
    end
  end

  // ************************************************************
  // flag sets routed to the owning group
  // ************************************************************
  wire [`FPRE_EXC_N-1:0] scSet;
  wire [`FPRE_EXC_N-1:0] sdSet;
  wire [`FPRE_EXC_N-1:0] next_scFlag;
  wire [`FPRE_EXC_N-1:0] next_sdFlag;

  genvar gi;
  generate
    for (gi = 0; gi < `FPRE_EXC_N; gi = gi + 1) begin : g_set
      assign scSet[gi] = opValid & ~opSimd & det[gi]; // RQ20
      assign sdSet[gi] = opValid & opSimd & det[gi]; // RQ20
    end
  endgenerate

  assign next_scFlag = flagNext(scFlag, wrScStat, wrScFlag, scSet); // RQ17
  assign next_sdFlag = flagNext(sdFlag, wrSdCsr, wrSdFlag, sdSet); // RQ17

  // ************************************************************
  // register state
  // ************************************************************
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      scMask <= `FPRE_MASK_RST;
      scRc <= `FPRE_RC_NEAREST; // RQ5
      scFlag <= `FPRE_FLAG_RST;
      sdMask <= `FPRE_MASK_RST;
      sdRc <= `FPRE_RC_NEAREST; // RQ5
      sdFlag <= `FPRE_FLAG_RST;
    end else begin
      if (wrScCtrl) begin
        scMask <= wrScMask; // RQ18
        scRc <= wrScRc; // RQ9
      end
      if (wrSdCsr) begin
        sdMask <= wrSdMask; // RQ19
        sdRc <= wrSdRc; // RQ9
      end
      scFlag <= next_scFlag; // RQ14
      sdFlag <= next_sdFlag; // RQ14
    end
  end

  // ************************************************************
  // read port, data one cycle after the strobe
  // ************************************************************
  reg [31:0] next_rd;

  always @* begin
    next_rd = 32'h0000_0000;
    case (regAddr)
      `FPRE_OFS_SCALAR_CTRL: begin
        next_rd[`FPRE_SC_MASK_LO+`FPRE_EXC_N-1:`FPRE_SC_MASK_LO] =
          scMask; // RQ18
        next_rd[`FPRE_SC_RC_LO+1:`FPRE_SC_RC_LO] = scRc; // RQ9
      end
      `FPRE_OFS_SCALAR_STAT: begin
        next_rd[`FPRE_EXC_N-1:0] = scFlag; // RQ18
      end
      `FPRE_OFS_SIMD_CSR: begin
        next_rd[`FPRE_SD_FLAG_LO+`FPRE_EXC_N-1:`FPRE_SD_FLAG_LO] =
          sdFlag; // RQ19
        next_rd[`FPRE_SD_MASK_LO+`FPRE_EXC_N-1:`FPRE_SD_MASK_LO] =
          sdMask; // RQ19
        next_rd[`FPRE_SD_RC_LO+1:`FPRE_SD_RC_LO] = sdRc; // RQ9
      end
      default: begin
        next_rd = 32'h0000_0000;
      end
    endcase
  end

  // read data held only in the answer cycle
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      regRdData <= 32'h0000_0000;
    end else if (regRdEn) begin
      regRdData <= next_rd;
    end else begin
      regRdData <= 32'h0000_0000;
    end
  end

  // ************************************************************
  // result outputs
  // ************************************************************
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      resValid <= 1'b0;
      resSign <= 1'b0;
      resMant <= {`FPRE_MANT_W{1'b0}};
      resKind <= `FPRE_KIND_FINITE;
      resFlags <= `FPRE_FLAG_RST;
      trapReq <= 1'b0;
    end else begin
      resValid <= opValid;
      trapReq <= opValid & trap; // RQ16
      if (opValid) begin
        resFlags <= det; // RQ14
        // unmasked: result fields hold, operands stay untouched
        if (!trap) begin
          resSign <= next_sign; // RQ15
          resMant <= next_mant; // RQ15
          resKind <= next_kind; // RQ15
        end
      end
    end
  end

endmodule // fpre_round_exc
